// [rtl/mccr_defines.vh]
// register addresses, field positions and reset values of the motor configuration bank
// assumes inclusion by bare name from rtl/ design files
`ifndef MCCR_DEFINES_VH
`define MCCR_DEFINES_VH
`define MCCR_ADDR_SRC     7'h00
`define MCCR_ADDR_ADV     7'h01
`define MCCR_ADDR_LOCK    7'h02
`define MCCR_ADDR_BASIC   7'h03
`define MCCR_ADDR_DRIVE   7'h04
`define MCCR_ADDR_FAULT   7'h2A
`define MCCR_NREGS        6
`define MCCR_RST_VAL      16'h0000
`define MCCR_FAULT_RST    16'h0018
`define MCCR_SRC_MASK     16'h003F
`define MCCR_ADV_MASK     16'h00FF
`define MCCR_DRIVE_MASK   16'h3FC0
`define MCCR_FAULT_MASK   16'h003F
`define MCCR_SPD_LSB      4
`define MCCR_FB_LSB       2
`define MCCR_BRK_BIT      1
`define MCCR_RETRY_BIT    0
`define MCCR_REVS_LSB     8
`define MCCR_BASIC_BIT    15
`define MCCR_TOL_LSB      12
`define MCCR_RSTR_LSB     12
`define MCCR_DELAY_BIT    11
`define MCCR_AADV_BIT     10
`define MCCR_AGAIN_BIT    9
`define MCCR_SINE_BIT     8
`define MCCR_TDRV_LSB     6
`define MCCR_SPD_CLKFREQ  2'h0
`define MCCR_SPD_CLKPWM   2'h1
`define MCCR_SPD_REG      2'h2
`define MCCR_TDRV_US0     1
`define MCCR_TDRV_US1     5
`define MCCR_TDRV_US2     10
`define MCCR_TDRV_US3     15
`define MCCR_CLK_MHZ      200
`define MCCR_LOCK_MS_X100 256
`define MCCR_ADV_DIV      960
`endif

// [rtl/mccr_regmem.v]
// small register storage with a registered read port
// assumes one writer and one reader on SYS_CLK
module mccr_regmem #(
   parameter DW = 16,
   parameter AW = 3,
   parameter N  = 6
) (
   input  wire          clk,
   input  wire          rst_n,
   input  wire          we,
   input  wire [AW-1:0] waddr,
   input  wire [DW-1:0] wdata,
   input  wire [AW-1:0] raddr,
   output reg  [DW-1:0] rdata_q
);
   reg [DW-1:0] mem_q [0:N-1];
   integer i;
   ////////////////////////////////////////////////////////////////////////
   // writes land one cycle later; read data always come from a flop
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         for (i = 0; i < N; i = i + 1)
            mem_q[i] <= {DW{1'b0}};
         rdata_q <= {DW{1'b0}};
      end
      else
      begin
         if (we)
            mem_q[waddr] <= wdata;
         rdata_q <= mem_q[raddr];
      end
   end
endmodule

// [rtl/mccr_top.v]
// configuration register bank of a sensored brushless motor controller
// assumes an already deserialised SPI word port on SYS_CLK and fabric-side motor logic
//
// Function
// - speed source field selects command source
// - feedback field selects speed measurement signal
// - brake bit chooses outputs while disabled
// - retry bit: latch off or auto retry
// - advance counts of hall period over 960
// - extra revolutions before lock flag
// - longest hall period for lock, 2.56ms
// - basic bit forces three-hall 120 commutation
// - tolerance code doubles from 1/512 rev
// - twelve-bit multiplier scales pwm duty
// - commutation counter reset every 1,2,4,8
// - direction bit: lead or lag hall
// - auto advance enable bit
// - auto gain enable bit
// - sinusoidal drive enable bit
// - high current gate drive time select
// - fault flags cleared by zero writes only
// - writes accepted at any time
module mccr_top #(
   parameter DW = 16
) (
   input  wire          SYS_CLK,
   input  wire          RST_N,
   input  wire          REG_WR,
   input  wire          REG_RD,
   input  wire [6:0]    REG_ADDR,
   input  wire [DW-1:0] REG_WDATA,
   input  wire [5:0]    FAULT_EVENT,
   input  wire          LOAD_VALID,
   input  wire [6:0]    LOAD_ADDR,
   input  wire [DW-1:0] LOAD_DATA,
   output reg  [DW-1:0] REG_RDATA,
   output reg           REG_RVALID,
   output reg  [1:0]    SPEED_COMMAND_SOURCE,
   output reg  [1:0]    FEEDBACK_SOURCE_SELECT,
   output reg           BRAKE_OUTPUT_STYLE,
   output reg           FAULT_RETRY,
   output reg  [7:0]    COMMUTATION_ADVANCE,
   output reg  [7:0]    EXTRA_LOCK_REVOLUTIONS,
   output reg  [7:0]    LOCK_MAX_PERIOD,
   output reg  [23:0]   LOCK_MAX_PERIOD_US,
   output reg           BASIC_MODE,
   output reg  [2:0]    LOCK_SPEED_TOLERANCE,
   output reg  [9:0]    LOCK_TOLERANCE_SHIFT,
   output reg  [11:0]   PWM_DUTY_SCALE,
   output reg           PWM_SCALE_ACTIVE,
   output reg  [1:0]    COMMUTATION_COUNTER_RESET_RATE,
   output reg  [3:0]    HALL_CYCLES_PER_RESET,
   output reg           ADVANCE_LAG,
   output reg           AUTO_ADVANCE_ENABLE,
   output reg           AUTO_GAIN_ENABLE,
   output reg           SINUSOIDAL_DRIVE_ENABLE,
   output reg  [1:0]    HIGH_CURRENT_DRIVE_TIME,
   output reg  [11:0]   DRIVE_TIME_CYCLES,
   output reg  [5:0]    FAULT_FLAGS
);
`include "mccr_defines.vh"

   // products are worked out as integers, then cut on purpose: drive times to the 12-bit port width, the lock step to 16 bits
   localparam integer TDRV_I0 = `MCCR_TDRV_US0 * `MCCR_CLK_MHZ;
   localparam integer TDRV_I1 = `MCCR_TDRV_US1 * `MCCR_CLK_MHZ;
   localparam integer TDRV_I2 = `MCCR_TDRV_US2 * `MCCR_CLK_MHZ;
   localparam integer TDRV_I3 = `MCCR_TDRV_US3 * `MCCR_CLK_MHZ;
   localparam integer LOCK_I  = `MCCR_LOCK_MS_X100 * 10;
   localparam [11:0] TDRV_C0 = TDRV_I0[11:0];
   localparam [11:0] TDRV_C1 = TDRV_I1[11:0];
   localparam [11:0] TDRV_C2 = TDRV_I2[11:0];
   localparam [11:0] TDRV_C3 = TDRV_I3[11:0];
   localparam [15:0] LOCK_US_STEP = LOCK_I[15:0];
   localparam [15:0] FAULT_RST = `MCCR_FAULT_RST;

   ////////////////////////////////////////////////////////////////////////
   // address decode: maps an offset to a storage slot, 7 marks unmapped
   function [2:0] slot_of;
      input [6:0] a;
      begin
         case (a)
            `MCCR_ADDR_SRC:   slot_of = 3'h0;
            `MCCR_ADDR_ADV:   slot_of = 3'h1;
            `MCCR_ADDR_LOCK:  slot_of = 3'h2;
            `MCCR_ADDR_BASIC: slot_of = 3'h3;
            `MCCR_ADDR_DRIVE: slot_of = 3'h4;
            `MCCR_ADDR_FAULT: slot_of = 3'h5;
            default:          slot_of = 3'h7;
         endcase
      end
   endfunction

   // reserved positions are stripped on storage so they never steer logic
   function [15:0] keep_mask;
      input [2:0] s;
      begin
         case (s)
            3'h0:    keep_mask = `MCCR_SRC_MASK;
            3'h1:    keep_mask = `MCCR_ADV_MASK;
            3'h4:    keep_mask = `MCCR_DRIVE_MASK;
            3'h5:    keep_mask = `MCCR_FAULT_MASK;
            default: keep_mask = 16'hFFFF;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // write arbitration: spi wins over a storage load in the same cycle
   wire [2:0]    spi_slot  = slot_of(REG_ADDR);
   wire [2:0]    load_slot = slot_of(LOAD_ADDR);
   wire          spi_cfg   = REG_WR && (spi_slot != 3'h7) && (spi_slot != 3'h5);
   wire          load_cfg  = LOAD_VALID && (load_slot != 3'h7) && (load_slot != 3'h5);
   wire          spi_fault = REG_WR && (spi_slot == 3'h5);
   wire          cfg_we    = spi_cfg | load_cfg;
   wire [2:0]    cfg_slot  = spi_cfg ? spi_slot : load_slot;
   wire [DW-1:0] cfg_raw   = spi_cfg ? REG_WDATA : LOAD_DATA;
   wire [DW-1:0] cfg_data  = cfg_raw & keep_mask(cfg_slot);

   wire [DW-1:0] mem_rdata;
   reg  [5:0]    fault_q;
   reg  [5:0]    fault_d;
   reg           rd_pend_q;
   reg           rd_fault_q;
   reg           rd_bad_q;

   ////////////////////////////////////////////////////////////////////////
   // readback storage; writes accepted in any cycle
   mccr_regmem #(
      .DW (DW),
      .AW (3),
      .N  (`MCCR_NREGS)
   ) u_mem (
      .clk     (SYS_CLK),
      .rst_n   (RST_N),
      .we      (cfg_we),
      .waddr   (cfg_slot),
      .wdata   (cfg_data),
      .raddr   (spi_slot),
      .rdata_q (mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // fault flags: written ones are ignored, zeros clear, a new event wins
   always @*
   begin
      fault_d = fault_q;
      if (spi_fault)
         fault_d = fault_q & REG_WDATA[5:0];
      fault_d = fault_d | FAULT_EVENT;
   end

   always @(posedge SYS_CLK)
   begin
      if (!RST_N)
         fault_q <= FAULT_RST[5:0];
      else
         fault_q <= fault_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // read path: two cycle latency, storage read data are already registered
   always @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         rd_pend_q  <= 1'b0;
         rd_fault_q <= 1'b0;
         rd_bad_q   <= 1'b0;
         REG_RDATA  <= `MCCR_RST_VAL;
         REG_RVALID <= 1'b0;
      end
      else
      begin
         rd_pend_q  <= REG_RD;
         rd_fault_q <= (spi_slot == 3'h5);
         rd_bad_q   <= (spi_slot == 3'h7);
         REG_RVALID <= rd_pend_q;
         if (rd_pend_q)
         begin
            if (rd_bad_q)
               REG_RDATA <= 16'h0000;
            else if (rd_fault_q)
               REG_RDATA <= {10'h000, fault_q};
            else
               REG_RDATA <= mem_rdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // shadow copies that drive the motor logic, updated on the write cycle
   reg [DW-1:0] src_q;
   reg [DW-1:0] adv_q;
   reg [DW-1:0] lock_q;
   reg [DW-1:0] basic_q;
   reg [DW-1:0] drive_q;

   always @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         src_q   <= `MCCR_RST_VAL;
         adv_q   <= `MCCR_RST_VAL;
         lock_q  <= `MCCR_RST_VAL;
         basic_q <= `MCCR_RST_VAL;
         drive_q <= `MCCR_RST_VAL;
      end
      else if (cfg_we)
      begin
         case (cfg_slot)
            3'h0:    src_q   <= cfg_data;
            3'h1:    adv_q   <= cfg_data;
            3'h2:    lock_q  <= cfg_data;
            3'h3:    basic_q <= cfg_data;
            3'h4:    drive_q <= cfg_data;
            default: src_q   <= src_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // field decode into registered control outputs
   always @(posedge SYS_CLK)
   begin
      if (!RST_N)
      begin
         SPEED_COMMAND_SOURCE           <= 2'h0;
         FEEDBACK_SOURCE_SELECT         <= 2'h0;
         BRAKE_OUTPUT_STYLE             <= 1'b0;
         FAULT_RETRY                    <= 1'b0;
         COMMUTATION_ADVANCE            <= 8'h00;
         EXTRA_LOCK_REVOLUTIONS         <= 8'h00;
         LOCK_MAX_PERIOD                <= 8'h00;
         LOCK_MAX_PERIOD_US             <= 24'h000000;
         BASIC_MODE                     <= 1'b0;
         LOCK_SPEED_TOLERANCE           <= 3'h0;
         LOCK_TOLERANCE_SHIFT           <= 10'h001;
         PWM_DUTY_SCALE                 <= 12'h000;
         PWM_SCALE_ACTIVE               <= 1'b0;
         COMMUTATION_COUNTER_RESET_RATE <= 2'h0;
         HALL_CYCLES_PER_RESET          <= 4'h1;
         ADVANCE_LAG                    <= 1'b0;
         AUTO_ADVANCE_ENABLE            <= 1'b0;
         AUTO_GAIN_ENABLE               <= 1'b0;
         SINUSOIDAL_DRIVE_ENABLE        <= 1'b0;
         HIGH_CURRENT_DRIVE_TIME        <= 2'h0;
         DRIVE_TIME_CYCLES              <= TDRV_C0;
         FAULT_FLAGS                    <= 6'h00;
      end
      else
      begin
         // reserved speed code 11 is passed through; loop treats it as off
         SPEED_COMMAND_SOURCE   <= src_q[`MCCR_SPD_LSB+1:`MCCR_SPD_LSB];
         FEEDBACK_SOURCE_SELECT <= src_q[`MCCR_FB_LSB+1:`MCCR_FB_LSB];
         BRAKE_OUTPUT_STYLE     <= src_q[`MCCR_BRK_BIT];
         FAULT_RETRY            <= src_q[`MCCR_RETRY_BIT];
         // basic mode zeroes advance so commutation follows the halls
         COMMUTATION_ADVANCE    <= basic_q[`MCCR_BASIC_BIT] ? 8'h00 : adv_q[7:0];
         BASIC_MODE             <= basic_q[`MCCR_BASIC_BIT];
         EXTRA_LOCK_REVOLUTIONS <= lock_q[`MCCR_REVS_LSB+7:`MCCR_REVS_LSB];
         LOCK_MAX_PERIOD        <= lock_q[7:0];
         LOCK_MAX_PERIOD_US     <= lock_q[7:0] * LOCK_US_STEP;
         LOCK_SPEED_TOLERANCE   <= basic_q[`MCCR_TOL_LSB+2:`MCCR_TOL_LSB];
         // tolerance in 1/512 rev units: 1 << code
         LOCK_TOLERANCE_SHIFT   <= 10'h001 << basic_q[`MCCR_TOL_LSB+2:`MCCR_TOL_LSB];
         PWM_DUTY_SCALE         <= basic_q[11:0];
         PWM_SCALE_ACTIVE       <= (src_q[`MCCR_SPD_LSB+1:`MCCR_SPD_LSB] == `MCCR_SPD_CLKPWM);
         COMMUTATION_COUNTER_RESET_RATE <= drive_q[`MCCR_RSTR_LSB+1:`MCCR_RSTR_LSB];
         HALL_CYCLES_PER_RESET  <= 4'h1 << drive_q[`MCCR_RSTR_LSB+1:`MCCR_RSTR_LSB];
         ADVANCE_LAG            <= drive_q[`MCCR_DELAY_BIT];
         AUTO_ADVANCE_ENABLE    <= drive_q[`MCCR_AADV_BIT];
         AUTO_GAIN_ENABLE       <= drive_q[`MCCR_AGAIN_BIT];
         SINUSOIDAL_DRIVE_ENABLE <= drive_q[`MCCR_SINE_BIT];
         HIGH_CURRENT_DRIVE_TIME <= drive_q[`MCCR_TDRV_LSB+1:`MCCR_TDRV_LSB];
         case (drive_q[`MCCR_TDRV_LSB+1:`MCCR_TDRV_LSB])
            2'h0:    DRIVE_TIME_CYCLES <= TDRV_C0;
            2'h1:    DRIVE_TIME_CYCLES <= TDRV_C1;
            2'h2:    DRIVE_TIME_CYCLES <= TDRV_C2;
            default: DRIVE_TIME_CYCLES <= TDRV_C3;
         endcase
         FAULT_FLAGS            <= fault_q;
      end
   end
endmodule

// [tb/mccr_host.sv]
// host-side model that writes and reads the configuration words
// assumes the word port behind the serial link, driven on falling edges
module mccr_host (
   input  logic        clk,
   input  logic        rvalid,
   input  logic [15:0] rdata,
   output logic        wr,
   output logic        rd,
   output logic [6:0]  addr,
   output logic [15:0] wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle bus at time zero
   initial
   begin
      wr = 1'b0;
      rd = 1'b0;
      addr = 7'h00;
      wdata = 16'h0000;
   end
   // strobe held across the taking edge; data inverted once released
   task automatic wr_word(input logic [6:0] a, input logic [15:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      wdata = ~d;
   endtask
   // answer looked for mid-cycle, as it stands for one cycle only
   task automatic rd_word(input logic [6:0] a, output logic [15:0] d);
      int n;
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      n = 0;
      d = 16'hXXXX;
      while (rvalid !== 1'b1 && n < 8)
      begin
         @(negedge clk);
         n++;
      end
      if (rvalid === 1'b1) d = rdata;
   endtask
endmodule

// [tb/mccr_chk.sv]
// assertions on the configuration bank ports
// assumes binding into mccr_top, one clock, synchronous active-low reset
module mccr_chk (
   input logic        SYS_CLK,
   input logic        RST_N,
   input logic        REG_WR,
   input logic        REG_RD,
   input logic [6:0]  REG_ADDR,
   input logic [15:0] REG_WDATA,
   input logic [5:0]  FAULT_EVENT,
   input logic        REG_RVALID,
   input logic [1:0]  SPEED_COMMAND_SOURCE,
   input logic [7:0]  COMMUTATION_ADVANCE,
   input logic [7:0]  LOCK_MAX_PERIOD,
   input logic [23:0] LOCK_MAX_PERIOD_US,
   input logic        BASIC_MODE,
   input logic [2:0]  LOCK_SPEED_TOLERANCE,
   input logic [9:0]  LOCK_TOLERANCE_SHIFT,
   input logic        PWM_SCALE_ACTIVE,
   input logic [1:0]  COMMUTATION_COUNTER_RESET_RATE,
   input logic [3:0]  HALL_CYCLES_PER_RESET,
   input logic        SINUSOIDAL_DRIVE_ENABLE,
   input logic [1:0]  HIGH_CURRENT_DRIVE_TIME,
   input logic [11:0] DRIVE_TIME_CYCLES,
   input logic [5:0]  FAULT_FLAGS
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_N);
   ////////////////////////////////////////////////////////////////////////////////
   // read answer timing both ways, so a stray pulse is caught too
   a_read_answer: assert property (REG_RD |-> ##2 REG_RVALID)
      else $error("read unanswered");
   a_answer_cause: assert property (REG_RVALID |-> $past(REG_RD, 2))
      else $error("stray answer");
   a_speed_write: assert property (REG_WR && REG_ADDR == 7'h00 |-> ##2
      SPEED_COMMAND_SOURCE == $past(REG_WDATA[5:4], 2)) else $error("speed source");
   a_sine_write: assert property (REG_WR && REG_ADDR == 7'h04 |-> ##2
      SINUSOIDAL_DRIVE_ENABLE == $past(REG_WDATA[8], 2)) else $error("sine bit");
   // derived outputs tied to their fields
   a_basic_adv: assert property (BASIC_MODE |-> COMMUTATION_ADVANCE == 8'h00)
      else $error("basic");
   a_tol_shift: assert property (LOCK_TOLERANCE_SHIFT == 10'h001 << LOCK_SPEED_TOLERANCE)
      else $error("tolerance");
   a_pwm_active: assert property (PWM_SCALE_ACTIVE == (SPEED_COMMAND_SOURCE == 2'h1))
      else $error("pwm scale");
   a_hall_rate: assert property (
      HALL_CYCLES_PER_RESET == 4'h1 << COMMUTATION_COUNTER_RESET_RATE) else $error("hall rate");
   a_period_us: assert property (LOCK_MAX_PERIOD_US == LOCK_MAX_PERIOD * 24'h000A00)
      else $error("lock period");
   a_drive_time: assert property (
      DRIVE_TIME_CYCLES == (HIGH_CURRENT_DRIVE_TIME == 2'h0 ? 12'h0C8 :
      HIGH_CURRENT_DRIVE_TIME == 2'h1 ? 12'h3E8 : HIGH_CURRENT_DRIVE_TIME == 2'h2 ? 12'h7D0 :
      12'hBB8)) else $error("drive time");
   a_fault_set: assert property (FAULT_EVENT[0] |-> ##2 FAULT_FLAGS[0])
      else $error("fault");
endmodule
bind mccr_top mccr_chk u_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .FAULT_EVENT(FAULT_EVENT), .REG_RVALID(REG_RVALID),
   .SPEED_COMMAND_SOURCE(SPEED_COMMAND_SOURCE), .COMMUTATION_ADVANCE(COMMUTATION_ADVANCE),
   .LOCK_MAX_PERIOD(LOCK_MAX_PERIOD), .LOCK_MAX_PERIOD_US(LOCK_MAX_PERIOD_US),
   .BASIC_MODE(BASIC_MODE), .LOCK_SPEED_TOLERANCE(LOCK_SPEED_TOLERANCE),
   .LOCK_TOLERANCE_SHIFT(LOCK_TOLERANCE_SHIFT), .PWM_SCALE_ACTIVE(PWM_SCALE_ACTIVE),
   .COMMUTATION_COUNTER_RESET_RATE(COMMUTATION_COUNTER_RESET_RATE),
   .HALL_CYCLES_PER_RESET(HALL_CYCLES_PER_RESET), .SINUSOIDAL_DRIVE_ENABLE(SINUSOIDAL_DRIVE_ENABLE),
   .HIGH_CURRENT_DRIVE_TIME(HIGH_CURRENT_DRIVE_TIME), .DRIVE_TIME_CYCLES(DRIVE_TIME_CYCLES),
   .FAULT_FLAGS(FAULT_FLAGS));

// [tb/tb_motor_control_config_registers.sv]
// self-checking bench of the configuration bank
// assumes mccr_top, mccr_host and mccr_chk compiled, rtl/ on the include path
`include "mccr_defines.vh"
module tb_motor_control_config_registers;
   timeunit 1ns;
   timeprecision 1ps;
   logic SYS_CLK = 1'b0, RST_N = 1'b0, WR, RD, RVALID, LOAD_VALID = 1'b0;
   logic BRK, RETRY, BASIC, PWMACT, LAG, AADV, AGAIN, SINE;
   logic [1:0] SPD, FB, RATE, TDRV;
   logic [2:0] TOL;
   logic [3:0] HALLN;
   logic [5:0] FAULT_EVENT = 6'h00, FAULT_FLAGS;
   logic [6:0] ADDR, LOAD_ADDR = 7'h00;
   logic [7:0] ADV, REVS, LMP;
   logic [9:0] TSH;
   logic [11:0] PWM, DCYC;
   logic [15:0] WDATA, RDATA, LOAD_DATA = 16'h0000, d, r;
   logic [23:0] LUS;
   int fail_count = 0, total_checks = 0, cyc = 0, seed = 87;
   always #2.5 SYS_CLK = ~SYS_CLK;
   mccr_top dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_WR(WR), .REG_RD(RD), .REG_ADDR(ADDR),
      .REG_WDATA(WDATA), .FAULT_EVENT(FAULT_EVENT), .LOAD_VALID(LOAD_VALID), .LOAD_ADDR(LOAD_ADDR),
      .LOAD_DATA(LOAD_DATA), .REG_RDATA(RDATA), .REG_RVALID(RVALID), .SPEED_COMMAND_SOURCE(SPD),
      .FEEDBACK_SOURCE_SELECT(FB), .BRAKE_OUTPUT_STYLE(BRK), .FAULT_RETRY(RETRY),
      .COMMUTATION_ADVANCE(ADV), .EXTRA_LOCK_REVOLUTIONS(REVS), .LOCK_MAX_PERIOD(LMP),
      .LOCK_MAX_PERIOD_US(LUS), .BASIC_MODE(BASIC), .LOCK_SPEED_TOLERANCE(TOL),
      .LOCK_TOLERANCE_SHIFT(TSH), .PWM_DUTY_SCALE(PWM), .PWM_SCALE_ACTIVE(PWMACT),
      .COMMUTATION_COUNTER_RESET_RATE(RATE), .HALL_CYCLES_PER_RESET(HALLN), .ADVANCE_LAG(LAG),
      .AUTO_ADVANCE_ENABLE(AADV), .AUTO_GAIN_ENABLE(AGAIN), .SINUSOIDAL_DRIVE_ENABLE(SINE),
      .HIGH_CURRENT_DRIVE_TIME(TDRV), .DRIVE_TIME_CYCLES(DCYC), .FAULT_FLAGS(FAULT_FLAGS));
   mccr_host host (.clk(SYS_CLK), .rvalid(RVALID), .rdata(RDATA), .wr(WR), .rd(RD), .addr(ADDR),
      .wdata(WDATA));
   ////////////////////////////////////////////////////////////////////////////////
   // stored bits of each word; unmapped places keep nothing
   function automatic logic [15:0] mask(input logic [6:0] a);
      case (a)
         7'h00: return `MCCR_SRC_MASK;
         7'h01: return `MCCR_ADV_MASK;
         7'h02, 7'h03: return 16'hFFFF;
         7'h04: return `MCCR_DRIVE_MASK;
         default: return 16'h0000;
      endcase
   endfunction
   // control outputs regathered into their word positions
   function automatic logic [15:0] fields(input logic [6:0] a);
      case (a)
         7'h00: return {10'h000, SPD, FB, BRK, RETRY};
         7'h01: return {8'h00, ADV};
         7'h02: return {REVS, LMP};
         7'h03: return {BASIC, TOL, PWM};
         default: return {2'h0, RATE, LAG, AADV, AGAIN, SINE, TDRV, 6'h00};
      endcase
   endfunction
   function automatic logic [11:0] cycles(input int k);
      int us[4] = '{`MCCR_TDRV_US0, `MCCR_TDRV_US1, `MCCR_TDRV_US2, `MCCR_TDRV_US3};
      return 12'(us[k] * `MCCR_CLK_MHZ);
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [23:0] g, input logic [23:0] e);
      total_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge SYS_CLK);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // hang guard well above the few hundred cycles the tests need
   always @(posedge SYS_CLK)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         summarize;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      tick(5);
      RST_N = 1'b1;
      chk(DCYC, cycles(0));
      host.rd_word(7'h2A, r);
      chk(r, `MCCR_FAULT_RST);
      $display("test reset done");
      // random words, basic bit kept clear so advance stays visible
      for (int i = 0; i < 40; i++)
      begin
         d = $random(seed);
         if (i % 5 == 3) d[15] = 1'b0;
         host.wr_word(7'(i % 5), d);
         tick(2);
         chk(fields(7'(i % 5)), d & mask(7'(i % 5)));
         chk(LUS, LMP * 24'h000A00);
         host.rd_word(7'(i % 5), r);
         chk(r, d & mask(7'(i % 5)));
      end
      $display("test random done");
      // every code of the tolerance, reset rate, drive time and speed source fields
      for (int k = 0; k < 8; k++)
      begin
         host.wr_word(7'h03, {1'b0, 3'(k), 12'hABC});
         host.wr_word(7'h04, {2'h0, 2'(k), 4'h0, 2'(k), 6'h00});
         host.wr_word(7'h00, {10'h000, 2'(k), 4'h0});
         tick(2);
         chk(TSH, 10'h001 << k);
         chk(HALLN, 4'h1 << (k % 4));
         chk(DCYC, cycles(k % 4));
         chk(PWMACT, (k % 4) == 1);
      end
      $display("test codes done");
      host.wr_word(7'h01, 16'h005A);
      host.wr_word(7'h03, 16'h8000);
      tick(2);
      chk(ADV, 8'h00);
      host.wr_word(7'h03, 16'h0000);
      tick(2);
      chk(ADV, 8'h5A);
      host.wr_word(7'h10, 16'hFFFF);
      host.rd_word(7'h10, r);
      chk(r, 16'h0000);
      $display("test basic and unmapped done");
      host.wr_word(7'h2A, 16'hFFFF);
      host.rd_word(7'h2A, r);
      chk(r, `MCCR_FAULT_RST);
      host.wr_word(7'h2A, 16'h0000);
      host.rd_word(7'h2A, r);
      chk(r, 16'h0000);
      @(negedge SYS_CLK) FAULT_EVENT = 6'h21;
      @(negedge SYS_CLK) FAULT_EVENT = 6'h00;
      tick(2);
      chk(FAULT_FLAGS, 6'h21);
      host.wr_word(7'h2A, 16'h0001);
      host.rd_word(7'h2A, r);
      chk(r, 16'h0001);
      // clear and new event on one edge: the event must survive
      fork
         host.wr_word(7'h2A, 16'h0000);
         begin
            @(negedge SYS_CLK) FAULT_EVENT = 6'h02;
            @(negedge SYS_CLK) FAULT_EVENT = 6'h00;
         end
      join
      host.rd_word(7'h2A, r);
      chk(r, 16'h0002);
      $display("test fault done");
      @(negedge SYS_CLK) {LOAD_VALID, LOAD_ADDR, LOAD_DATA} = {1'b1, 7'h01, 16'h0033};
      @(negedge SYS_CLK) {LOAD_VALID, LOAD_DATA} = {1'b0, 16'hFFCC};
      host.rd_word(7'h01, r);
      chk(r, 16'h0033);
      host.wr_word(7'h01, 16'h00C4);
      host.rd_word(7'h01, r);
      chk(r, 16'h00C4);
      $display("test load done");
      summarize;
   end
endmodule
